// [nbf_pkg.sv]
// Constants, field layout and state types of the boot flash controller.
// Assumes one 40 MHz clock and a plain address/strobe register port.
//
// Contract
// - After reset with auto boot, copy first 4 KB of flash into boot SRAM.
// - When the copy ends, boot SRAM is mapped at chip select zero.
// - Boot copy does no parity checking; first boot region must be error free.
// - Auto boot only when the two boot mode pins read 00.
// - Address cycle select 0 gives three address cycles, 1 gives four.
// - Parity is computed over each 512-byte block on writes and reads.
// - Parity of one block is exactly three bytes.
// - 18 line bits plus 6 column bits, packed into bytes 0, 1 and 2.
// - Reads compute fresh parity; software compares and corrects.
// - Config bit 15 enables; cleared after auto boot; software sets it.
// - Writing 1 to config bit 12 restarts the parity generator.
// - Config bit 11 drives chip enable; left inactive after auto boot.
// - Bits 10:8 give latch enable setup before the strobe of value plus one clocks.
// - Bits 6:4 give strobe active width of value plus one clocks.
// - Bits 2:0 give hold after strobe of value plus one clocks.
// - Command register write issues a command cycle.
// - Address register write issues an address cycle.
// - Drive latch enables, chip, read, write enables; share data port; sample ready.
// - Boot SRAM stays usable as general memory after boot.
// - Status bit 0 shows ready input: 0 busy, 1 ready.
// - Data register write programs a byte; read returns a flash byte.
// - Parity register: byte 2 at 23:16, byte 1 at 15:8, byte 0 at 7:0.
package nbf_pkg;
   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [31:0] OFS_CONFIG = 32'h4e00_0000;
   localparam logic [31:0] OFS_COMMAND = 32'h4e00_0004;
   localparam logic [31:0] OFS_ADDRESS = 32'h4e00_0008;
   localparam logic [31:0] OFS_DATA = 32'h4e00_000c;
   localparam logic [31:0] OFS_STATUS = 32'h4e00_0010;
   localparam logic [31:0] OFS_PARITY = 32'h4e00_0014;
   localparam logic [31:0] OFS_SRAM_PTR = 32'h4e00_0018;
   localparam logic [31:0] OFS_SRAM_DATA = 32'h4e00_001c;
   // ****************************************************************
   // Field positions and reset values
   // ****************************************************************
   localparam int CFG_EN_BIT = 15;
   localparam int CFG_ECC_INIT_BIT = 12;
   localparam int CFG_CE_BIT = 11;
   localparam int CFG_LATCH_SETUP_TIME_LSB = 8;
   localparam int CFG_TW0_LSB = 4;
   localparam int CFG_TW1_LSB = 0;
   localparam int STAT_READY_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;
   localparam int STAT_BOOTING_BIT = 2;
   localparam int STAT_BOOTED_BIT = 3;
   localparam logic CFG_EN_RESET = 1'b0;
   localparam logic CFG_CE_RESET = 1'b1;
   localparam logic [2:0] CFG_TIME_RESET = 3'h0;
   localparam logic [7:0] CMD_RESET = 8'h00;
   localparam logic [7:0] ADDR_RESET = 8'h00;
   // ****************************************************************
   // Boot copy and timing
   // ****************************************************************
   localparam logic [1:0] BOOT_MODE_AUTO = 2'h0;
   localparam logic [7:0] BOOT_READ_CMD = 8'h00;
   localparam logic [11:0] BOOT_LAST_BYTE = 12'hfff;
   localparam logic [8:0] PAGE_LAST_BYTE = 9'h1ff;
   localparam int CLK_PERIOD_PS = 25000;
   localparam int BUSY_ONSET_NS = 200;
   localparam logic [3:0] BUSY_ONSET_CYC = 4'((BUSY_ONSET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {ENG_IDLE, ENG_SETUP, ENG_ACTIVE, ENG_HOLD} nbf_eng_state_t;
   typedef enum logic [1:0] {OP_CMD, OP_ADDR, OP_WR, OP_RD} nbf_op_t;
   typedef enum logic [3:0] {BOOT_SAMPLE, BOOT_OFF, BOOT_CMD, BOOT_ADDR, BOOT_WAIT_BUSY, BOOT_WAIT_READY,
      BOOT_READ, BOOT_FINISH, BOOT_DONE} nbf_boot_state_t;
endpackage

// [nbf_nand_boot_ctrl.sv]
// Boot flash controller: auto boot copy, cycle sequencer, parity generator.
// Assumes a synchronous 8-bit flash on the pins and a plain register port.
module nbf_nand_boot_ctrl (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [31:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [31:0] bus_rdata,
   input wire logic [1:0] boot_mode_pins,
   input wire logic address_cycle_select,
   input wire logic flash_ready_busy_n,
   input wire logic [7:0] flash_data_in,
   output logic [7:0] flash_data_out,
   output logic flash_data_oe,
   output logic flash_cle,
   output logic flash_ale,
   output logic flash_chip_en_n,
   output logic flash_read_en_n,
   output logic flash_write_en_n,
   output logic chip_select_zero_sram,
   output logic boot_done
);
   import nbf_pkg::*;

   // ****************************************************************
   // Reset release
   // ****************************************************************
   logic rst_meta_reg;
   logic rst_n_reg;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg <= rst_meta_reg;
      end
   end

   // ****************************************************************
   // State
   // ****************************************************************
   logic cfg_en_reg, cfg_en_next;
   logic cfg_ce_reg, cfg_ce_next;
   logic [2:0] cfg_latch_setup_time_reg, cfg_latch_setup_time_next;
   logic [2:0] cfg_tw0_reg, cfg_tw0_next;
   logic [2:0] cfg_tw1_reg, cfg_tw1_next;
   logic [7:0] cmd_reg, cmd_next;
   logic [7:0] adr_reg, adr_next;
   logic [11:0] ptr_reg, ptr_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [7:0] rx_reg, rx_next;
   logic ready_reg;
   nbf_eng_state_t eng_reg, eng_next;
   logic [2:0] cnt_reg, cnt_next;
   nbf_op_t op_reg, op_next;
   logic [7:0] byte_reg, byte_next;
   nbf_boot_state_t boot_reg, boot_next;
   logic [11:0] bcnt_reg, bcnt_next;
   logic [1:0] acnt_reg, acnt_next;
   logic [3:0] wait_reg, wait_next;
   logic cs0_reg, cs0_next;
   logic done_reg, done_next;
   logic cle_reg, cle_next;
   logic ale_reg, ale_next;
   logic ce_n_reg, ce_n_next;
   logic re_n_reg, re_n_next;
   logic we_n_reg, we_n_next;
   logic oe_reg, oe_next;
   logic [7:0] dq_reg, dq_next;
   logic [8:0] lp_reg, lp_next;
   logic [8:0] lpn_reg, lpn_next;
   logic [2:0] cp_reg, cp_next;
   logic [2:0] cpn_reg, cpn_next;
   logic [8:0] idx_reg, idx_next;
   logic [7:0] mem [0:4095];
   logic [23:0] parity;
   logic booting, sw_ok, eng_done, ecc_take, ecc_init, sram_we, act;
   logic [11:0] sram_wa;
   logic [7:0] sram_wd, ecc_byte;

   assign booting = (boot_reg != BOOT_OFF) && (boot_reg != BOOT_DONE) && (boot_reg != BOOT_SAMPLE);
   // Byte 0, byte 1, byte 2 packing
   assign parity = {cp_reg[2], cpn_reg[2], cp_reg[1], cpn_reg[1], cp_reg[0], cpn_reg[0], lp_reg[8], lpn_reg[8],
      lp_reg[7], lpn_reg[7], lp_reg[6], lpn_reg[6], lp_reg[5], lpn_reg[5], lp_reg[4], lpn_reg[4],
      lp_reg[3], lpn_reg[3], lp_reg[2], lpn_reg[2], lp_reg[1], lpn_reg[1], lp_reg[0], lpn_reg[0]};

   // ****************************************************************
   // Control next state
   // ****************************************************************
   always_comb begin
      cfg_en_next = cfg_en_reg;
      cfg_ce_next = cfg_ce_reg;
      cfg_latch_setup_time_next = cfg_latch_setup_time_reg;
      cfg_tw0_next = cfg_tw0_reg;
      cfg_tw1_next = cfg_tw1_reg;
      cmd_next = cmd_reg;
      adr_next = adr_reg;
      ptr_next = ptr_reg;
      rdata_next = 32'h0000_0000;
      rx_next = rx_reg;
      eng_next = eng_reg;
      cnt_next = cnt_reg;
      op_next = op_reg;
      byte_next = byte_reg;
      boot_next = boot_reg;
      bcnt_next = bcnt_reg;
      acnt_next = acnt_reg;
      wait_next = wait_reg;
      cs0_next = cs0_reg;
      done_next = done_reg;
      eng_done = 1'b0;
      ecc_take = 1'b0;
      ecc_init = 1'b0;
      ecc_byte = 8'h00;
      sram_we = 1'b0;
      sram_wa = ptr_reg;
      sram_wd = bus_wdata[7:0];
      sw_ok = cfg_en_reg && (eng_reg == ENG_IDLE) && !booting;
      // Cycle engine: setup, active, hold
      case (eng_reg)
         ENG_IDLE: begin
         end
         ENG_SETUP: begin
            if (cnt_reg == cfg_latch_setup_time_reg) begin
               eng_next = ENG_ACTIVE;
               cnt_next = 3'h0;
            end else begin
               cnt_next = cnt_reg + 3'h1;
            end
         end
         ENG_ACTIVE: begin
            if (cnt_reg == cfg_tw0_reg) begin
               eng_next = ENG_HOLD;
               cnt_next = 3'h0;
               if (op_reg == OP_RD) begin
                  rx_next = flash_data_in;
               end
            end else begin
               cnt_next = cnt_reg + 3'h1;
            end
         end
         ENG_HOLD: begin
            if (cnt_reg == cfg_tw1_reg) begin
               eng_next = ENG_IDLE;
               eng_done = 1'b1;
            end else begin
               cnt_next = cnt_reg + 3'h1;
            end
         end
         default: begin
            eng_next = ENG_IDLE;
         end
      endcase
      // Parity only on data bytes moved by software
      if (eng_done && !booting && ((op_reg == OP_WR) || (op_reg == OP_RD))) begin
         ecc_take = 1'b1;
         ecc_byte = (op_reg == OP_WR) ? byte_reg : rx_reg;
      end
      // Register writes
      if (bus_wr) begin
         case (bus_addr)
            OFS_CONFIG: begin
               cfg_en_next = bus_wdata[CFG_EN_BIT];
               ecc_init = bus_wdata[CFG_ECC_INIT_BIT];
               cfg_ce_next = bus_wdata[CFG_CE_BIT];
               cfg_latch_setup_time_next = bus_wdata[CFG_LATCH_SETUP_TIME_LSB +: 3];
               cfg_tw0_next = bus_wdata[CFG_TW0_LSB +: 3];
               cfg_tw1_next = bus_wdata[CFG_TW1_LSB +: 3];
            end
            OFS_COMMAND: begin
               cmd_next = bus_wdata[7:0];
               if (sw_ok) begin
                  eng_next = ENG_SETUP;
                  op_next = OP_CMD;
                  byte_next = bus_wdata[7:0];
                  cnt_next = 3'h0;
               end
            end
            OFS_ADDRESS: begin
               adr_next = bus_wdata[7:0];
               if (sw_ok) begin
                  eng_next = ENG_SETUP;
                  op_next = OP_ADDR;
                  byte_next = bus_wdata[7:0];
                  cnt_next = 3'h0;
               end
            end
            OFS_DATA: begin
               if (sw_ok) begin
                  eng_next = ENG_SETUP;
                  op_next = OP_WR;
                  byte_next = bus_wdata[7:0];
                  cnt_next = 3'h0;
               end
            end
            OFS_SRAM_PTR: begin
               ptr_next = bus_wdata[11:0];
            end
            OFS_SRAM_DATA: begin
               if (!booting) begin
                  sram_we = 1'b1;
                  ptr_next = ptr_reg + 12'h001;
               end
            end
            default: begin
            end
         endcase
      end
      // Register reads
      if (bus_rd) begin
         case (bus_addr)
            OFS_CONFIG: begin
               rdata_next = {16'h0000, cfg_en_reg, 3'h0, cfg_ce_reg, cfg_latch_setup_time_reg, 1'b0, cfg_tw0_reg, 1'b0,
                  cfg_tw1_reg};
            end
            OFS_COMMAND: begin
               rdata_next = {24'h00_0000, cmd_reg};
            end
            OFS_ADDRESS: begin
               rdata_next = {24'h00_0000, adr_reg};
            end
            OFS_DATA: begin
               rdata_next = {24'h00_0000, rx_reg};
               if (sw_ok) begin
                  eng_next = ENG_SETUP;
                  op_next = OP_RD;
                  cnt_next = 3'h0;
               end
            end
            OFS_STATUS: begin
               rdata_next[STAT_READY_BIT] = ready_reg;
               rdata_next[STAT_BUSY_BIT] = (eng_reg != ENG_IDLE);
               rdata_next[STAT_BOOTING_BIT] = booting;
               rdata_next[STAT_BOOTED_BIT] = done_reg;
            end
            OFS_PARITY: begin
               rdata_next = {8'h00, parity};
            end
            OFS_SRAM_PTR: begin
               rdata_next = {20'h0_0000, ptr_reg};
            end
            OFS_SRAM_DATA: begin
               rdata_next = {24'h00_0000, mem[ptr_reg]};
               ptr_next = ptr_reg + 12'h001;
            end
            default: begin
            end
         endcase
      end
      // Auto boot copy
      case (boot_reg)
         BOOT_SAMPLE: begin
            boot_next = (boot_mode_pins == BOOT_MODE_AUTO) ? BOOT_CMD : BOOT_OFF;
         end
         BOOT_CMD: begin
            if (eng_reg == ENG_IDLE) begin
               eng_next = ENG_SETUP;
               op_next = OP_CMD;
               byte_next = BOOT_READ_CMD;
               cnt_next = 3'h0;
               acnt_next = 2'h0;
               boot_next = BOOT_ADDR;
            end
         end
         BOOT_ADDR: begin
            if (eng_reg == ENG_IDLE) begin
               eng_next = ENG_SETUP;
               op_next = OP_ADDR;
               byte_next = (acnt_reg == 2'h1) ? {5'h00, bcnt_reg[11:9]} : 8'h00;
               cnt_next = 3'h0;
               acnt_next = acnt_reg + 2'h1;
               if (acnt_reg == (address_cycle_select ? 2'h3 : 2'h2)) begin
                  boot_next = BOOT_WAIT_BUSY;
                  wait_next = 4'h0;
               end
            end
         end
         BOOT_WAIT_BUSY: begin
            if (eng_reg == ENG_IDLE) begin
               wait_next = wait_reg + 4'h1;
               if (wait_reg == BUSY_ONSET_CYC) begin
                  boot_next = BOOT_WAIT_READY;
               end
            end
         end
         BOOT_WAIT_READY: begin
            if (ready_reg) begin
               boot_next = BOOT_READ;
            end
         end
         BOOT_READ: begin
            if (eng_reg == ENG_IDLE) begin
               eng_next = ENG_SETUP;
               op_next = OP_RD;
               cnt_next = 3'h0;
            end
            if (eng_done) begin
               sram_we = 1'b1;
               sram_wa = bcnt_reg;
               sram_wd = rx_reg;
               bcnt_next = bcnt_reg + 12'h001;
               if (bcnt_reg == BOOT_LAST_BYTE) begin
                  boot_next = BOOT_FINISH;
               end else if (bcnt_reg[8:0] == PAGE_LAST_BYTE) begin
                  boot_next = BOOT_CMD;
               end
            end
         end
         BOOT_FINISH: begin
            cfg_en_next = 1'b0;
            cfg_ce_next = 1'b1;
            cs0_next = 1'b1;
            done_next = 1'b1;
            boot_next = BOOT_DONE;
         end
         BOOT_OFF, BOOT_DONE: begin
         end
         default: begin
            boot_next = BOOT_OFF;
         end
      endcase
      // Pin values follow the next engine state
      act = (eng_next != ENG_IDLE);
      cle_next = act && (op_next == OP_CMD);
      ale_next = act && (op_next == OP_ADDR);
      we_n_next = !((eng_next == ENG_ACTIVE) && (op_next != OP_RD));
      re_n_next = !((eng_next == ENG_ACTIVE) && (op_next == OP_RD));
      oe_next = act && (op_next != OP_RD);
      dq_next = byte_next;
      if ((boot_next != BOOT_OFF) && (boot_next != BOOT_DONE) && (boot_next != BOOT_SAMPLE)) begin
         ce_n_next = 1'b0;
      end else begin
         ce_n_next = cfg_en_next ? cfg_ce_next : 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         cfg_en_reg <= CFG_EN_RESET;
         cfg_ce_reg <= CFG_CE_RESET;
         cfg_latch_setup_time_reg <= CFG_TIME_RESET;
         cfg_tw0_reg <= CFG_TIME_RESET;
         cfg_tw1_reg <= CFG_TIME_RESET;
         cmd_reg <= CMD_RESET;
         adr_reg <= ADDR_RESET;
         ptr_reg <= 12'h000;
         rdata_reg <= 32'h0000_0000;
         rx_reg <= 8'h00;
         ready_reg <= 1'b0;
         eng_reg <= ENG_IDLE;
         cnt_reg <= 3'h0;
         op_reg <= OP_CMD;
         byte_reg <= 8'h00;
         boot_reg <= BOOT_SAMPLE;
         bcnt_reg <= 12'h000;
         acnt_reg <= 2'h0;
         wait_reg <= 4'h0;
         cs0_reg <= 1'b0;
         done_reg <= 1'b0;
         cle_reg <= 1'b0;
         ale_reg <= 1'b0;
         ce_n_reg <= 1'b1;
         re_n_reg <= 1'b1;
         we_n_reg <= 1'b1;
         oe_reg <= 1'b0;
         dq_reg <= 8'h00;
      end else begin
         cfg_en_reg <= cfg_en_next;
         cfg_ce_reg <= cfg_ce_next;
         cfg_latch_setup_time_reg <= cfg_latch_setup_time_next;
         cfg_tw0_reg <= cfg_tw0_next;
         cfg_tw1_reg <= cfg_tw1_next;
         cmd_reg <= cmd_next;
         adr_reg <= adr_next;
         ptr_reg <= ptr_next;
         rdata_reg <= rdata_next;
         rx_reg <= rx_next;
         ready_reg <= flash_ready_busy_n;
         eng_reg <= eng_next;
         cnt_reg <= cnt_next;
         op_reg <= op_next;
         byte_reg <= byte_next;
         boot_reg <= boot_next;
         bcnt_reg <= bcnt_next;
         acnt_reg <= acnt_next;
         wait_reg <= wait_next;
         cs0_reg <= cs0_next;
         done_reg <= done_next;
         cle_reg <= cle_next;
         ale_reg <= ale_next;
         ce_n_reg <= ce_n_next;
         re_n_reg <= re_n_next;
         we_n_reg <= we_n_next;
         oe_reg <= oe_next;
         dq_reg <= dq_next;
      end
   end

   // ****************************************************************
   // Boot SRAM
   // ****************************************************************
   always_ff @(posedge ref_clk) begin
      if (sram_we) begin
         mem[sram_wa] <= sram_wd;
      end
   end

   // ****************************************************************
   // Parity generator
   // ****************************************************************
   logic byte_par;
   assign byte_par = ^ecc_byte;
   genvar k;
   generate
      for (k = 0; k < 9; k++) begin : g_line
         // Line parity for byte index bit k
         assign lp_next[k] = ecc_init ? 1'b0 : (lp_reg[k] ^ (ecc_take && idx_reg[k] && byte_par));
         assign lpn_next[k] = ecc_init ? 1'b0 : (lpn_reg[k] ^ (ecc_take && !idx_reg[k] && byte_par));
      end
   endgenerate

   always_comb begin
      cp_next = cp_reg;
      cpn_next = cpn_reg;
      idx_next = idx_reg;
      if (ecc_init) begin
         cp_next = 3'h0;
         cpn_next = 3'h0;
         idx_next = 9'h000;
      end else if (ecc_take) begin
         cp_next[0] = cp_reg[0] ^ ecc_byte[1] ^ ecc_byte[3] ^ ecc_byte[5] ^ ecc_byte[7];
         cpn_next[0] = cpn_reg[0] ^ ecc_byte[0] ^ ecc_byte[2] ^ ecc_byte[4] ^ ecc_byte[6];
         cp_next[1] = cp_reg[1] ^ ecc_byte[2] ^ ecc_byte[3] ^ ecc_byte[6] ^ ecc_byte[7];
         cpn_next[1] = cpn_reg[1] ^ ecc_byte[0] ^ ecc_byte[1] ^ ecc_byte[4] ^ ecc_byte[5];
         cp_next[2] = cp_reg[2] ^ (^ecc_byte[7:4]);
         cpn_next[2] = cpn_reg[2] ^ (^ecc_byte[3:0]);
         idx_next = idx_reg + 9'h001;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         lp_reg <= 9'h000;
         lpn_reg <= 9'h000;
         cp_reg <= 3'h0;
         cpn_reg <= 3'h0;
         idx_reg <= 9'h000;
      end else begin
         lp_reg <= lp_next;
         lpn_reg <= lpn_next;
         cp_reg <= cp_next;
         cpn_reg <= cpn_next;
         idx_reg <= idx_next;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign bus_rdata = rdata_reg;
   assign flash_data_out = dq_reg;
   assign flash_data_oe = oe_reg;
   assign flash_cle = cle_reg;
   assign flash_ale = ale_reg;
   assign flash_chip_en_n = ce_n_reg;
   assign flash_read_en_n = re_n_reg;
   assign flash_write_en_n = we_n_reg;
   assign chip_select_zero_sram = cs0_reg;
   assign boot_done = done_reg;
endmodule

// [nbf_nand_boot_ctrl_properties.sv]
// Checker of flash strobe widths, bus read data and boot end.
// Assumes binding to the controller top, one clock.
module nbf_chk (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [31:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [31:0] bus_rdata,
   input wire logic flash_data_oe,
   input wire logic flash_chip_en_n,
   input wire logic flash_read_en_n,
   input wire logic flash_write_en_n,
   input wire logic chip_select_zero_sram,
   input wire logic boot_done
);
   import nbf_pkg::*;
   logic [2:0] tw0_reg, tw0_next;
   logic [3:0] lo_reg, lo_next;
   always_comb begin
      tw0_next = (bus_wr && bus_addr == OFS_CONFIG) ? bus_wdata[6:4] : tw0_reg;
      lo_next = (flash_write_en_n && flash_read_en_n) ? 4'h0 : lo_reg + 4'h1;
   end
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         tw0_reg <= 3'h0;
         lo_reg <= 4'h0;
      end else begin
         tw0_reg <= tw0_next;
         lo_reg <= lo_next;
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);
   property p_we_width;
      $rose(flash_write_en_n) |-> lo_reg == {1'b0, tw0_reg} + 4'h1;
   endproperty
   a_we_width: assert property (p_we_width) else $error("write strobe width");
   property p_re_width;
      $rose(flash_read_en_n) |-> lo_reg == {1'b0, tw0_reg} + 4'h1;
   endproperty
   a_re_width: assert property (p_re_width) else $error("read strobe width");
   property p_we_oe;
      !flash_write_en_n |-> flash_data_oe;
   endproperty
   a_we_oe: assert property (p_we_oe) else $error("bus not driven");
   property p_re_oe;
      !flash_read_en_n |-> !flash_data_oe;
   endproperty
   a_re_oe: assert property (p_re_oe) else $error("bus driven on read");
   property p_rd_idle;
      !bus_rd |=> bus_rdata == 32'h0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
   property p_boot_end;
      $rose(boot_done) |-> flash_chip_en_n && chip_select_zero_sram;
   endproperty
   a_boot_end: assert property (p_boot_end) else $error("boot end pins");
   property p_boot_keep;
      boot_done |=> boot_done && chip_select_zero_sram;
   endproperty
   a_boot_keep: assert property (p_boot_keep) else $error("boot map lost");
   c_boot: cover property ($rose(boot_done));
   c_we: cover property ($rose(flash_write_en_n));
   c_re: cover property ($rose(flash_read_en_n));
endmodule
bind nbf_nand_boot_ctrl nbf_chk nbf_chk_inst (.ref_clk(ref_clk), .nrst(nrst), .bus_addr(bus_addr),
   .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .flash_data_oe(flash_data_oe),
   .flash_chip_en_n(flash_chip_en_n), .flash_read_en_n(flash_read_en_n), .flash_write_en_n(flash_write_en_n),
   .chip_select_zero_sram(chip_select_zero_sram), .boot_done(boot_done));

// [nbf_flash_model.sv]
// Behavioural flash: busy spell after a command, counted page reads.
// Assumes the bench resolves the shared data bus.
module nbf_flash_model (
   input wire logic ref_clk,
   input wire logic flash_cle,
   input wire logic flash_chip_en_n,
   input wire logic flash_read_en_n,
   input wire logic flash_write_en_n,
   output logic [7:0] flash_data_in,
   output logic flash_ready_busy_n
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [8:0] idx = 9'h0;
   logic [7:0] last = 8'h0;
   int busy = 0;
   initial flash_ready_busy_n = 1'b1;
   always @(posedge flash_write_en_n) begin
      if (flash_cle === 1'b1) begin
         idx = 9'h0;
         busy = 12;
      end
   end
   always @(posedge ref_clk) begin
      if (busy > 0) busy--;
      flash_ready_busy_n <= (busy == 0);
   end
   always @(posedge flash_read_en_n) begin
      last = idx[7:0] ^ 8'h5a;
      idx++;
   end
   // Released bus shows the inverse of the last byte
   assign flash_data_in = (!flash_read_en_n && !flash_chip_en_n) ? idx[7:0] ^ 8'h5a : ~last;
endmodule

// [nbf_nand_boot_ctrl_bench.sv]
// Bench of the boot flash controller.
// Assumes the flash model and the bound checker.
module nbf_nand_boot_ctrl_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import nbf_pkg::*;
   logic ref_clk, nrst, bus_wr, bus_rd, oe, cle, ale, ce_n, re_n, we_n, cs0, done, rb_n, sel;
   logic [1:0] mode;
   logic [31:0] bus_addr, bus_wdata, bus_rdata, d;
   logic [7:0] dq_out, dq_in, m_out, wr_byte;
   logic [31:0] pa[2] = '{32'h1ff, 32'hffd};
   int n_mismatch, cmp_count, i, n_ale, k0;
`define CMP(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; $display("wrong value at %0t: %h", $time, a); end end
   nbf_nand_boot_ctrl nbf_nand_boot_ctrl_inst (.ref_clk(ref_clk), .nrst(nrst), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .boot_mode_pins(mode),
      .address_cycle_select(sel), .flash_ready_busy_n(rb_n), .flash_data_in(dq_in), .flash_data_out(dq_out),
      .flash_data_oe(oe), .flash_cle(cle), .flash_ale(ale), .flash_chip_en_n(ce_n), .flash_read_en_n(re_n),
      .flash_write_en_n(we_n), .chip_select_zero_sram(cs0), .boot_done(done));
   assign dq_in = oe ? dq_out : m_out;
   always @(posedge ale) n_ale++;
   always @(posedge we_n) wr_byte = dq_out;
   nbf_flash_model nbf_flash_model_inst (.ref_clk(ref_clk), .flash_cle(cle), .flash_chip_en_n(ce_n),
      .flash_read_en_n(re_n), .flash_write_en_n(we_n), .flash_data_in(m_out), .flash_ready_busy_n(rb_n));
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      bus_addr <= a;
      bus_wdata <= v;
      bus_wr <= 1'b1;
      @(posedge ref_clk);
      bus_wr <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a);
      @(posedge ref_clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge ref_clk);
      bus_rd <= 1'b0;
      #1 d = bus_rdata;
   endtask
   task automatic poll(input int b, input logic v);
      for (int k = 0; k < 40; k++) begin
         rd(OFS_STATUS);
         if (d[b] === v) break;
      end
   endtask
   task automatic restart(input logic [1:0] m, input logic s);
      @(posedge ref_clk);
      nrst <= 1'b0;
      mode <= m;
      sel <= s;
      k0 = n_ale;
      repeat (5) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge ref_clk);
   endtask
   task automatic stop_test;
      if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #1500000;
      n_mismatch++;
      stop_test;
   end
   initial begin
      nrst = 1'b0;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_addr = 32'h0;
      bus_wdata = 32'h0;
      mode = 2'h0;
      sel = 1'b0;
      repeat (5) @(posedge ref_clk);
      nrst <= 1'b1;
      for (i = 0; i < 40000 && done !== 1'b1; i++) @(posedge ref_clk);
      `CMP(cs0, 1'b1)
      `CMP(ce_n, 1'b1)
      `CMP(n_ale, 24)
      rd(OFS_CONFIG);
      `CMP(d, 32'h800)
      rd(OFS_STATUS);
      `CMP(d, 32'h9)
      foreach (pa[i]) begin
         wr(OFS_SRAM_PTR, pa[i]);
         for (int j = 0; j < 3; j++) begin
            rd(OFS_SRAM_DATA);
            `CMP(d, {24'h0, 8'(pa[i] + j) ^ 8'h5a})
         end
      end
      wr(OFS_SRAM_PTR, 32'h10);
      wr(OFS_SRAM_DATA, 32'h3c);
      wr(OFS_SRAM_PTR, 32'h10);
      rd(OFS_SRAM_DATA);
      `CMP(d, 32'h3c)
      rd(32'h4e000020);
      `CMP(d, 32'h0)
      wr(OFS_CONFIG, 32'h9221);
      rd(OFS_PARITY);
      `CMP(d, 32'h0)
      wr(OFS_DATA, 32'h1);
      poll(1, 1'b0);
      `CMP(wr_byte, 8'h01)
      wr(OFS_COMMAND, 32'h190);
      poll(1, 1'b0);
      `CMP(d[0], 1'b0)
      `CMP(wr_byte, 8'h90)
      wr(OFS_ADDRESS, 32'h3);
      poll(1, 1'b0);
      `CMP(wr_byte, 8'h03)
      rd(OFS_PARITY);
      `CMP(d, 32'h555555)
      rd(OFS_COMMAND);
      `CMP(d, 32'h90)
      rd(OFS_ADDRESS);
      `CMP(d, 32'h3)
      poll(0, 1'b1);
      wr(OFS_CONFIG, 32'h9221);
      rd(OFS_DATA);
      poll(1, 1'b0);
      rd(OFS_DATA);
      `CMP(d, 32'h5a)
      poll(1, 1'b0);
      rd(OFS_PARITY);
      `CMP(d, 32'h555556)
      restart(2'h1, 1'b1);
      rd(OFS_STATUS);
      `CMP(d, 32'h1)
      `CMP(cs0, 1'b0)
      `CMP(n_ale - k0, 0)
      restart(2'h0, 1'b1);
      for (i = 0; i < 40000 && done !== 1'b1; i++) @(posedge ref_clk);
      `CMP(done, 1'b1)
      `CMP(n_ale - k0, 32)
      stop_test;
   end
endmodule
